// ==== bench/cra_chk.sv ====
// Port assertions for the CAN register access engine
`timescale 1ns/1ps
`default_nettype none
module cra_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic [10:0] rx_id,
   input wire logic [3:0]  rx_dlc,
   input wire logic [63:0] rx_data,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic        reg_req,
   input wire logic        reg_ack,
   input wire logic [15:0] reg_addr,
   input wire logic        remote_enable,
   input wire logic        output_enable,
   input wire logic        resistance_control_mode,
   input wire logic        volt_current_power_mode,
   input wire logic        alarm_ack
);
   // Frame taken, and taken control word at reset bases
   wire logic take = rx_valid && rx_ready;
   wire logic cw   = take && rx_id == cra_pkg::RST_CS_BASE && rx_dlc >= 4'h2;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_qry;
      take && rx_id == cra_pkg::RST_BASE_ID + cra_pkg::QRY_OFS && rx_dlc >= 4'h2;
   endsequence
   sequence s_bcw;
      take && rx_id == cra_pkg::RST_BCAST_ID && rx_dlc == 4'h5 && rx_data[47:40] == 8'h01;
   endsequence
   a_cw_bits: assert property (cw |=> {resistance_control_mode, output_enable, remote_enable}
      == $past(rx_data[50:48])) else $error("control bits wrong");
   a_alarm_ack: assert property (cw |=> alarm_ack == $past(rx_data[51]))
      else $error("alarm ack wrong");
   a_mode_inv: assert property (volt_current_power_mode != resistance_control_mode)
      else $error("mode outputs equal");
   a_tx_stable: assert property (tx_valid && !tx_ready |=> tx_valid
      && $stable({tx_id, tx_dlc, tx_data})) else $error("tx frame changed");
   a_req_hold: assert property (reg_req && !reg_ack |=> reg_req) else $error("req dropped");
   a_query_req: assert property (s_qry |=> reg_req) else $error("query not started");
   a_bcast_wr: assert property (s_bcw |=> reg_req && reg_addr == $past(rx_data[63:48]))
      else $error("broadcast write lost");
   a_busy_refuse: assert property (reg_req || tx_valid |-> !rx_ready)
      else $error("rx taken while busy");
   a_err_dlc: assert property (tx_valid && tx_data[63:48] == cra_pkg::ERR_REG
      |-> tx_dlc == cra_pkg::ERR_DLC && tx_data[39:0] == 40'h0) else $error("error frame shape");
endmodule : cra_chk
bind cra_can_access cra_chk u_chk (.*);
`default_nettype wire

// ==== bench/cra_regmap_model.sv ====
// Register map partner: acks on the third cycle, page 0xEE fails
`timescale 1ns/1ps
`default_nettype none
module cra_regmap_model (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        reg_req,
   input wire logic        reg_we,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic            reg_ack,
   output logic [15:0]     reg_rdata,
   output logic            reg_err,
   output logic [7:0]      reg_err_code
);
   logic [15:0] mem [256];
   logic [1:0]  cnt;
   // Slow answer, stale data inverted every cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 2'h0; reg_ack <= 1'b0; reg_err <= 1'b0; reg_err_code <= 8'h00; reg_rdata <= 16'h0;
         foreach (mem[i]) mem[i] <= 16'h0;
      end else begin
         reg_ack <= 1'b0; reg_err <= 1'b0; reg_rdata <= ~reg_rdata;
         if (reg_req && !reg_ack) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h2) begin
               cnt <= 2'h0; reg_ack <= 1'b1; reg_rdata <= mem[reg_addr[7:0]];
               reg_err <= reg_addr[15:8] == 8'hEE; reg_err_code <= 8'h03;
               if (reg_we && reg_addr[15:8] != 8'hEE) mem[reg_addr[7:0]] <= reg_wdata;
            end
         end
      end
   end
endmodule : cra_regmap_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the CAN register access engine
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ready, tx_valid;
   logic tx_ready, reg_req, reg_we, reg_ack, reg_err, link_up, remote_enable, output_enable;
   logic resistance_control_mode, volt_current_power_mode, alarm_ack, bad;
   logic [7:0]  paddr, reg_err_code;
   logic [31:0] pwdata, prdata, device_status;
   logic [10:0] rx_id, tx_id;
   logic [3:0]  rx_dlc, tx_dlc;
   logic [63:0] rx_data, tx_data;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, set_voltage, set_current, set_power, set_resistance;
   logic [3:0][63:0] cyc_data;
   logic [32:0] r;
   int n_errors, num_checks, w;
   cra_can_access #(.TICK_CYC(10)) uut (.*);
   cra_regmap_model u_map (.*);
   task automatic chk(input logic [79:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk); psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = {pslverr, prdata}; psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      @(posedge pclk); rx_valid <= 1'b1; rx_id <= id; rx_dlc <= dlc; rx_data <= d;
      do @(posedge pclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0; rx_data <= ~d;
   endtask : send
   task automatic xt(input logic [78:0] e); // Expected transmit frame
      w = 0;
      do begin @(posedge pclk); w++; end while (tx_valid !== 1'b1);
      chk(80'({tx_id, tx_dlc, tx_data}), 80'(e));
      tx_ready <= 1'b1; @(posedge pclk); tx_ready <= 1'b0;
   endtask : xt
   task automatic wrap_up;
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++; wrap_up();
   end
   initial begin
      {presetn, psel, penable, pwrite, rx_valid, tx_ready, link_up, bad} = '0;
      {paddr, pwdata, rx_id, rx_dlc, rx_data} = '0;
      device_status = 32'hA5C3_0F1E; cyc_data = {4{64'h1122_3344_5566_7788}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1; link_up <= 1'b1;
      apb(0, 8'h00, 0); chk(80'(r), 80'(33'h100));
      apb(0, 8'h04, 0); chk(80'(r), 80'(33'h0FF));
      apb(0, 8'h3C, 0); chk(80'(r), 80'(33'h1_0000_0000));
      send(11'h100, 4'h5, 64'h0192_01FF_0000_0000); send(11'h101, 4'h2, 64'h0192 << 48);
      xt({11'h102, 4'h4, 64'h0192_FF00_0000_0000});
      send(11'h0FF, 4'h5, 64'h0010_012A_2A00_0000);
      send(11'h101, 4'h3, 64'h0010_0300 << 32);
      xt({11'h102, 4'h8, 64'h0010_2A2A_0000_0000});
      send(11'h100, 4'h8, 64'h0020_04FE_3333_4444);
      send(11'h100, 4'h8, 64'h0020_04FF_1111_2222);
      send(11'h101, 4'h3, 64'h0020_0400 << 32); xt({11'h102, 4'h8, 64'h0020_FF11_1122_2233});
      xt({11'h102, 4'h6, 64'h0020_FE33_4444_0000});
      send(11'h0FF, 4'h2, 64'h0192 << 48); send(11'h100, 4'h5, 64'hEE05_0112_3400_0000);
      xt({11'h102, 4'h3, 64'hFFFF_0300_0000_0000});
      send(11'h200, 4'h2, 64'h000D << 48); @(posedge pclk); #1;
      chk(80'({volt_current_power_mode, resistance_control_mode, output_enable, remote_enable}),
          80'h5);
      send(11'h200, 4'h2, 64'h0002 << 48); @(posedge pclk); #1;
      chk(80'({volt_current_power_mode, output_enable, remote_enable}), 80'h6);
      send(11'h201, 4'h8, 64'h1111_2222_3333_4444); @(posedge pclk); #1;
      chk(80'({set_voltage, set_current, set_power, set_resistance}), 80'h1111_2222_3333_4444);
      apb(1, 8'h14, 5); apb(1, 8'h18, 20); apb(1, 8'h10, 1);
      xt({11'h300, 4'h4, 64'hA5C3_0F1E_0000_0000}); chk(80'(w > 185 && w < 215), 80'h1);
      xt({11'h301, 4'h6, 64'h1122_3344_5566_0000}); chk(80'(w < 3), 80'h1);
      apb(1, 8'h10, 0);
      repeat (250) begin @(posedge pclk); bad |= tx_valid; end
      chk(80'(bad), 80'h0);
      apb(1, 8'h00, 32'h180); send(11'h181, 4'h2, 64'h0192 << 48);
      xt({11'h182, 4'h4, 64'h0192_FF00_0000_0000});
      wrap_up();
   end
endmodule : tb
`default_nettype wire

// ==== hdl/cra_can_access.sv ====
// CAN register access engine: write, query, cyclic send and cyclic read
`timescale 1ns/1ps
`default_nettype none
module cra_can_access #(
   parameter int TICK_CYC = cra_pkg::TICK_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Received CAN frames
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [10:0] rx_id,
   input  wire logic [3:0]  rx_dlc,
   input  wire logic [63:0] rx_data,
   // Transmitted CAN frames
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [10:0]      tx_id,
   output logic [3:0]       tx_dlc,
   output logic [63:0]      tx_data,
   // Internal register map
   output logic             reg_req,
   output logic             reg_we,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic        reg_ack,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_err,
   input  wire logic [7:0]  reg_err_code,
   // Connection state and cyclic data
   input  wire logic        link_up,
   input  wire logic [31:0] device_status,
   input  wire logic [3:0][63:0] cyc_data,
   // Cyclic send outputs
   output logic             remote_enable,
   output logic             output_enable,
   output logic             resistance_control_mode,
   output logic             volt_current_power_mode,
   output logic             alarm_ack,
   output logic [15:0]      set_voltage,
   output logic [15:0]      set_current,
   output logic [15:0]      set_power,
   output logic [15:0]      set_resistance
);
   typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_QRD, ST_QPUT, ST_TX} cra_state_e;

   cra_state_e       state;
   logic [10:0]      base_id;
   logic [10:0]      bcast_id;
   logic [10:0]      cs_base;
   logic [10:0]      cr_base;
   logic             cr_en;
   logic [4:0][15:0] ivl;
   logic [7:0]       last_err;
   logic [15:0]      rx_cnt;
   logic             wr_two;
   logic [15:0]      wr_next;
   logic [15:0]      q_start;
   logic [8:0]       q_rem;
   logic             q_lo;
   logic [15:0]      rword;
   logic [7:0]       marker;
   logic [3:0]       pos;

   cra_cyc_if cyc ();

   // ----------
   // APB decode
   // ----------
   // Setup and access phases, each access answers at once
   wire        apb_setup = psel & ~penable;
   wire        apb_wr    = psel & penable & pwrite;
   wire [7:0]  ivl_rel   = paddr - cra_pkg::OFS_IVL0;
   wire [2:0]  ivl_idx   = ivl_rel[4:2];
   wire        ivl_hit   = (paddr >= cra_pkg::OFS_IVL0) & (paddr <= cra_pkg::OFS_IVL4) &
                           (paddr[1:0] == 2'b00);
   wire        hit_base  = (paddr == cra_pkg::OFS_BASE_ID);
   wire        hit_bcast = (paddr == cra_pkg::OFS_BCAST_ID);
   wire        hit_cs    = (paddr == cra_pkg::OFS_CS_BASE);
   wire        hit_cr    = (paddr == cra_pkg::OFS_CR_BASE);
   wire        hit_en    = (paddr == cra_pkg::OFS_CR_EN);
   wire        hit_stat  = (paddr == cra_pkg::OFS_STATUS);
   wire        hit_rxcnt = (paddr == cra_pkg::OFS_RXCNT);
   wire        hit_any   = hit_base | hit_bcast | hit_cs | hit_cr | hit_en | ivl_hit |
                           hit_stat | hit_rxcnt;
   wire        busy      = (state != ST_IDLE);
   wire [31:0] status_w  = {16'h0000, last_err, 7'h00, busy};

   // Read selection
   wire [31:0] rd_mux =
      hit_base  ? 32'(base_id)  :
      hit_bcast ? 32'(bcast_id) :
      hit_cs    ? 32'(cs_base)  :
      hit_cr    ? 32'(cr_base)  :
      hit_en    ? 32'(cr_en)    :
      ivl_hit   ? 32'(ivl[ivl_idx]) :
      hit_stat  ? status_w :
      hit_rxcnt ? 32'(rx_cnt) : 32'h00000000;

   assign pready = 1'b1;

   // Read data and error latched in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= ~hit_any;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_id  <= cra_pkg::RST_BASE_ID;
         bcast_id <= cra_pkg::RST_BCAST_ID;
         cs_base  <= cra_pkg::RST_CS_BASE;
         cr_base  <= cra_pkg::RST_CR_BASE;
         cr_en    <= 1'b0;
         ivl      <= '0;
      end else if (apb_wr) begin
         if (hit_base)  base_id  <= pwdata[10:0];
         if (hit_bcast) bcast_id <= pwdata[10:0];
         if (hit_cs)    cs_base  <= pwdata[10:0];
         if (hit_cr)    cr_base  <= pwdata[10:0];
         if (hit_en)    cr_en    <= pwdata[0]; // [R20]
         if (ivl_hit)   ivl[ivl_idx] <= pwdata[15:0];
      end
   end

   // ----------
   // Received frame decode
   // ----------
   // Payload fields, byte 0 most significant
   wire [15:0] rx_reg   = rx_data[63:48]; // [R23]
   wire [7:0]  rx_cnt_f = rx_data[47:40];
   wire [7:0]  rx_mark  = rx_data[39:32];
   wire [15:0] rx_val1  = rx_data[39:24];
   wire [15:0] rx_wd0   = rx_data[31:16];
   wire [15:0] rx_wd1   = rx_data[15:0];

   // Identifier classes, query and answer ids track the base
   wire [10:0] qry_id   = base_id + cra_pkg::QRY_OFS; // [R22]
   wire [10:0] rsp_id   = base_id + cra_pkg::RSP_OFS; // [R13] [R22]
   wire        is_cw    = (rx_id == cs_base) & (rx_dlc >= cra_pkg::CW_DLC);
   wire        is_sv    = (rx_id == cs_base + cra_pkg::CS_SET_OFS) &
                          (rx_dlc == cra_pkg::FULL_DLC); // [R08]
   wire        is_wr_id = (rx_id == base_id) | (rx_id == bcast_id); // [R01]
   wire        is_qry   = (rx_id == qry_id) & (rx_dlc >= cra_pkg::CW_DLC); // [R12] [R21]
   wire        is_sgl   = (rx_dlc == cra_pkg::SINGLE_DLC) &
                          (rx_cnt_f == cra_pkg::SINGLE_CNT); // [R02]
   wire        is_mul   = (rx_dlc == cra_pkg::FULL_DLC); // [R03] [R07]

   // Register offset of a split piece from its marker
   wire [15:0] m_off    = {7'h00, ~rx_mark, 1'b0}; // [R05] [R06]
   wire        m_ok0    = (m_off < {8'h00, rx_cnt_f}); // [R04]
   wire        m_ok1    = (m_off + 16'h0001 < {8'h00, rx_cnt_f});
   wire [15:0] m_addr   = rx_reg + m_off;

   // Query length, count byte when present
   wire [7:0]  q_cnt_in = (rx_dlc >= cra_pkg::ERR_DLC && rx_cnt_f != 8'h00) ?
                          rx_cnt_f : cra_pkg::SINGLE_CNT;
   wire        q_split  = (q_cnt_in > cra_pkg::MAX_SGL_REGS); // [R14] [R15]

   // ----------
   // Cyclic read arbitration
   // ----------
   // Lowest due object wins, others follow back to back
   wire [2:0] due_idx =
      cyc.due[0] ? 3'd0 : cyc.due[1] ? 3'd1 : cyc.due[2] ? 3'd2 :
      cyc.due[3] ? 3'd3 : 3'd4; // [R18]
   wire       cyc_go  = (state == ST_IDLE) & (|cyc.due);

   assign cyc.enable   = cr_en;
   assign cyc.link_up  = link_up;
   assign cyc.interval = ivl;
   assign cyc.take     = cyc_go;
   assign cyc.take_idx = due_idx;

   // Object payload, status first, bytes past its length cleared
   wire [63:0] cyc_keep = ~(64'hFFFFFFFFFFFFFFFF >> {cra_pkg::CYC_DLC[due_idx], 3'b000});
   wire [63:0] cyc_pay  = cyc_keep & ((due_idx == 3'd0) ? {device_status, 32'h00000000} :
                                      cyc_data[2'(due_idx - 3'd1)]); // [R17]

   cra_cyc_sched #(
      .TICK_CYC (TICK_CYC)
   ) u_sched (
      .pclk    (pclk),
      .presetn (presetn),
      .cyc     (cyc)
   );

   // ----------
   // Handshakes
   // ----------
   assign rx_ready = (state == ST_IDLE) & ~cyc_go;
   assign tx_valid = (state == ST_TX);
   assign reg_req  = (state == ST_WR) | (state == ST_QRD);
   assign volt_current_power_mode = ~resistance_control_mode;
   wire   rx_take  = rx_valid & rx_ready;
   wire [7:0] q_byte = q_lo ? rword[7:0] : rword[15:8]; // [R23]

   // ----------
   // Cyclic send outputs
   // ----------
   // Control word bits applied together in the cycle after the frame is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_enable           <= 1'b0;
         output_enable           <= 1'b0;
         resistance_control_mode <= 1'b0;
         alarm_ack               <= 1'b0;
      end else begin
         alarm_ack <= rx_take & is_cw & rx_data[48 + cra_pkg::CW_ALARM]; // [R10]
         if (rx_take && is_cw) begin
            remote_enable           <= rx_data[48 + cra_pkg::CW_REMOTE]; // [R09] [R11]
            output_enable           <= rx_data[48 + cra_pkg::CW_OUTPUT]; // [R09] [R11]
            resistance_control_mode <= rx_data[48 + cra_pkg::CW_RMODE];  // [R09]
         end
      end
   end

   // Four set values in one frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_voltage    <= 16'h0000;
         set_current    <= 16'h0000;
         set_power      <= 16'h0000;
         set_resistance <= 16'h0000;
      end else if (rx_take && !is_cw && is_sv) begin
         set_voltage    <= rx_data[63:48]; // [R08]
         set_current    <= rx_data[47:32];
         set_power      <= rx_data[31:16];
         set_resistance <= rx_data[15:0];
      end
   end

   // Accepted frame counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rx_cnt <= 16'h0000;
      else if (rx_take) rx_cnt <= rx_cnt + 16'h0001;
   end

   // ----------
   // Frame engine
   // ----------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= ST_IDLE;
         reg_we    <= 1'b0;
         reg_addr  <= 16'h0000;
         reg_wdata <= 16'h0000;
         wr_two    <= 1'b0;
         wr_next   <= 16'h0000;
         q_start   <= 16'h0000;
         q_rem     <= 9'h000;
         q_lo      <= 1'b0;
         rword     <= 16'h0000;
         marker    <= 8'h00;
         pos       <= 4'h0;
         tx_id     <= 11'h000;
         tx_dlc    <= 4'h0;
         tx_data   <= '0;
         last_err  <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (cyc_go) begin
                  tx_id   <= cr_base + {8'h00, due_idx}; // [R17]
                  tx_dlc  <= cra_pkg::CYC_DLC[due_idx];
                  tx_data <= cyc_pay;
                  q_rem   <= 9'h000;
                  state   <= ST_TX;
               end else if (rx_take && !is_cw && !is_sv && is_wr_id && is_sgl) begin
                  reg_we    <= 1'b1;
                  reg_addr  <= rx_reg; // [R02]
                  reg_wdata <= rx_val1;
                  wr_two    <= 1'b0;
                  state     <= ST_WR;
               end else if (rx_take && !is_cw && !is_sv && is_wr_id && is_mul && m_ok0) begin
                  reg_we    <= 1'b1;
                  reg_addr  <= m_addr; // [R03] [R06]
                  reg_wdata <= rx_wd0;
                  wr_next   <= rx_wd1;
                  wr_two    <= m_ok1; // [R04] [R07]
                  state     <= ST_WR;
               end else if (rx_take && !is_cw && !is_sv && !is_wr_id && is_qry) begin
                  reg_we  <= 1'b0;
                  reg_addr <= rx_reg; // [R12]
                  q_start <= rx_reg;
                  q_rem   <= {q_cnt_in, 1'b0};
                  q_lo    <= 1'b0;
                  marker  <= cra_pkg::MARK_FIRST; // [R05]
                  pos     <= q_split ? cra_pkg::SPLIT_POS : cra_pkg::SGL_POS;
                  tx_id   <= rsp_id; // [R13]
                  tx_data <= q_split ? {rx_reg, cra_pkg::MARK_FIRST, 40'h0000000000} :
                                       {rx_reg, 48'h000000000000}; // [R14] [R15]
                  state   <= ST_QRD;
               end
            end
            ST_WR: begin
               if (reg_ack && reg_err) begin
                  tx_id    <= rsp_id;
                  tx_dlc   <= cra_pkg::ERR_DLC;
                  tx_data  <= {cra_pkg::ERR_REG, reg_err_code, 40'h0000000000}; // [R16]
                  last_err <= reg_err_code;
                  q_rem    <= 9'h000;
                  state    <= ST_TX;
               end else if (reg_ack && wr_two) begin
                  reg_addr  <= reg_addr + 16'h0001;
                  reg_wdata <= wr_next;
                  wr_two    <= 1'b0;
               end else if (reg_ack) begin
                  reg_we <= 1'b0;
                  state  <= ST_IDLE;
               end
            end
            ST_QRD: begin
               if (reg_ack && reg_err) begin
                  tx_dlc   <= cra_pkg::ERR_DLC;
                  tx_data  <= {cra_pkg::ERR_REG, reg_err_code, 40'h0000000000}; // [R16]
                  last_err <= reg_err_code;
                  q_rem    <= 9'h000;
                  state    <= ST_TX;
               end else if (reg_ack) begin
                  rword <= reg_rdata;
                  q_lo  <= 1'b0;
                  state <= ST_QPUT;
               end
            end
            ST_QPUT: begin
               tx_data[{~pos[2:0], 3'b000} +: 8] <= q_byte; // [R23]
               pos   <= pos + 4'h1;
               q_rem <= q_rem - 9'h001;
               q_lo  <= ~q_lo;
               if (q_lo) reg_addr <= reg_addr + 16'h0001;
               if (pos == cra_pkg::FULL_DLC - 4'h1 || q_rem == 9'h001) begin
                  tx_dlc <= pos + 4'h1; // [R14] [R15]
                  state  <= ST_TX;
               end else if (q_lo) begin
                  state <= ST_QRD;
               end
            end
            ST_TX: begin
               if (tx_ready && q_rem != 9'h000) begin
                  marker  <= marker - 8'h01; // [R05] [R15]
                  tx_data <= {q_start, marker - 8'h01, 40'h0000000000};
                  pos     <= cra_pkg::SPLIT_POS;
                  state   <= q_lo ? ST_QPUT : ST_QRD;
               end else if (tx_ready) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule : cra_can_access
`default_nettype wire

// ==== hdl/cra_cyc_if.sv ====
// Link between frame engine and cyclic read scheduler
`timescale 1ns/1ps
`default_nettype none
interface cra_cyc_if;
   logic             enable;
   logic             link_up;
   logic [4:0][15:0] interval;
   logic [4:0]       due;
   logic             take;
   logic [2:0]       take_idx;
   modport ctrl  (output enable, link_up, interval, take, take_idx, input due);
   modport sched (input enable, link_up, interval, take, take_idx, output due);
endinterface : cra_cyc_if
`default_nettype wire

// ==== hdl/cra_cyc_sched.sv ====
// Cyclic read scheduler: per object millisecond timers
`timescale 1ns/1ps
`default_nettype none
module cra_cyc_sched #(
   parameter int TICK_CYC = cra_pkg::TICK_CYC
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   cra_cyc_if.sched   cyc
);
   localparam int PW = $clog2(TICK_CYC + 1);

   logic [PW-1:0]    pre;
   logic [4:0][15:0] ms_cnt;
   logic [4:0]       pend;
   logic [4:0]       active;
   logic [4:0]       fire;
   wire              tick = (pre == PW'(TICK_CYC - 1));

   // ----------
   // Millisecond prescaler
   // ----------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre <= '0;
      else pre <= tick ? '0 : pre + PW'(1);
   end

   // Object active and interval elapsed
   for (genvar g = 0; g < cra_pkg::NOBJ; g++) begin : g_obj
      assign active[g] = cyc.enable & cyc.link_up & (cyc.interval[g] != 16'h0000); // [R17] [R20]
      assign fire[g]   = active[g] & tick &
                         (ms_cnt[g] >= cra_pkg::clamp_ivl(cyc.interval[g]) - 16'h0001); // [R19]
   end

   // Timers and pending flags, a new fire wins over take
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= '0;
         pend   <= '0;
      end else begin
         for (int i = 0; i < cra_pkg::NOBJ; i++) begin
            if (!active[i]) ms_cnt[i] <= 16'h0000;
            else if (tick) ms_cnt[i] <= fire[i] ? 16'h0000 : ms_cnt[i] + 16'h0001;
            if (fire[i]) pend[i] <= 1'b1;
            else if (!active[i] || (cyc.take && cyc.take_idx == 3'(i))) pend[i] <= 1'b0;
         end
      end
   end

   assign cyc.due = pend;
endmodule : cra_cyc_sched
`default_nettype wire

// ==== hdl/cra_pkg.sv ====
// Constants, field positions and helpers for the CAN register access block
//
// Functional notes
// [R01] Writes accepted on base or broadcast identifier
// [R02] Single write: register, count one, value
// [R03] Multi write: start, count, marker, four bytes
// [R04] Count equals registers forming the object
// [R05] Marker starts 0xFF, decrements per message
// [R06] Reassemble split data by marker, not arrival
// [R07] Four data bytes always, count may shrink
// [R08] Cyclic send: control word, then set values
// [R09] Control bits: remote, output, resistance mode
// [R10] Control bit 3 acknowledges all alarms
// [R11] Control bits acted together, no priority
// [R12] Query on base plus one, start register
// [R13] Answers sent on base plus two
// [R14] Up to three registers: one reply message
// [R15] More than three: split, marker, five bytes
// [R16] Failed access: 65535 and error code
// [R17] Five cyclic objects, nonzero interval enables
// [R18] Coinciding cyclic objects sent back to back
// [R19] Cyclic interval never below twenty ms
// [R20] Cyclic sending runs while connected, switchable
// [R21] Broadcast identifier takes writes only
// [R22] Query and answer identifiers follow base
// [R23] Multi-byte fields sent most significant first
package cra_pkg;
   // ----------
   // APB register offsets
   // ----------
   localparam logic [7:0]  OFS_BASE_ID  = 8'h00;
   localparam logic [7:0]  OFS_BCAST_ID = 8'h04;
   localparam logic [7:0]  OFS_CS_BASE  = 8'h08;
   localparam logic [7:0]  OFS_CR_BASE  = 8'h0C;
   localparam logic [7:0]  OFS_CR_EN    = 8'h10;
   localparam logic [7:0]  OFS_IVL0     = 8'h14;
   localparam logic [7:0]  OFS_IVL4     = 8'h24;
   localparam logic [7:0]  OFS_STATUS   = 8'h28;
   localparam logic [7:0]  OFS_RXCNT    = 8'h2C;
   // ----------
   // Reset values
   // ----------
   localparam logic [10:0] RST_BASE_ID  = 11'h100;
   localparam logic [10:0] RST_BCAST_ID = 11'h0FF;
   localparam logic [10:0] RST_CS_BASE  = 11'h200;
   localparam logic [10:0] RST_CR_BASE  = 11'h300;
   // ----------
   // Frame layout
   // ----------
   localparam logic [10:0] QRY_OFS      = 11'h001;
   localparam logic [10:0] RSP_OFS      = 11'h002;
   localparam logic [10:0] CS_SET_OFS   = 11'h001;
   localparam logic [7:0]  MARK_FIRST   = 8'hFF;
   localparam logic [15:0] ERR_REG      = 16'hFFFF;
   localparam logic [7:0]  SINGLE_CNT   = 8'h01;
   localparam logic [3:0]  SINGLE_DLC   = 4'h5;
   localparam logic [3:0]  FULL_DLC     = 4'h8;
   localparam logic [3:0]  CW_DLC       = 4'h2;
   localparam logic [3:0]  ERR_DLC      = 4'h3;
   localparam logic [3:0]  SGL_POS      = 4'h2;
   localparam logic [3:0]  SPLIT_POS    = 4'h3;
   localparam logic [7:0]  MAX_SGL_REGS = 8'h03;
   localparam int          CW_REMOTE    = 0;
   localparam int          CW_OUTPUT    = 1;
   localparam int          CW_RMODE     = 2;
   localparam int          CW_ALARM     = 3;
   // ----------
   // Cyclic read timing and objects
   // ----------
   localparam int          NOBJ         = 5;
   localparam logic [15:0] MIN_IVL_MS   = 16'd20;
   localparam int          MS_NS        = 1000000;
   localparam int          CLK_NS       = 10;
   localparam int          TICK_CYC     = MS_NS / CLK_NS;
   localparam logic [4:0][3:0] CYC_DLC  = {4'h4, 4'h8, 4'h8, 4'h6, 4'h4};

   // Byte i of a payload, byte 0 in the top bits
   function automatic logic [7:0] get_byte(input logic [63:0] d, input logic [2:0] i);
      return d[{~i, 3'b000} +: 8];
   endfunction : get_byte

   // Interval in ms raised to the floor
   function automatic logic [15:0] clamp_ivl(input logic [15:0] iv);
      return (iv < MIN_IVL_MS) ? MIN_IVL_MS : iv;
   endfunction : clamp_ivl
endpackage : cra_pkg
